/* File: hw/adc_pkg.sv */
package adc_pkg;

  localparam int CLK_HZ = 125_000_000;
  localparam int MCLK_PER_TCLK = 1;

  localparam int DOUT_RELEASE_TARGET_TCLK = 8;
  localparam int LINK_SYNC_LAT_CYC = 3;
  localparam int RELEASE_CYC =
    DOUT_RELEASE_TARGET_TCLK * MCLK_PER_TCLK - LINK_SYNC_LAT_CYC;
  localparam int UPDATE_TCLK = 16;
  localparam int UPDATE_CYC = UPDATE_TCLK * MCLK_PER_TCLK;
  localparam int MAX_RATE_SPS = 16000;
  localparam int PERIOD_16K_CYC = CLK_HZ / MAX_RATE_SPS;
  localparam int CAL_CYC_DEFAULT = 2048;

  // Register addresses and reset values.
  localparam logic [1:0] REG_INPUT_MUX = 2'h0;
  localparam logic [1:0] REG_GAIN = 2'h1;
  localparam logic [1:0] REG_RATE = 2'h2;
  localparam logic [1:0] REG_BUFFER = 2'h3;
  localparam logic [7:0] INPUT_MUX_RESET = 8'h01;
  localparam logic [2:0] GAIN_RESET = 3'h0;
  localparam logic [2:0] GAIN_MAX_CODE = 3'h6;
  localparam logic [3:0] RATE_RESET = 4'h0;

  // Command opcodes; register commands carry the address in bits 1:0.
  localparam logic [3:0] OP_REG_READ = 4'h1;
  localparam logic [3:0] OP_REG_WRITE = 4'h5;
  localparam logic [7:0] OP_WAKEUP = 8'h00;
  localparam logic [7:0] OP_READ_RESULT = 8'h01;
  localparam logic [7:0] OP_READ_CONT = 8'h03;
  localparam logic [7:0] OP_SELF_OFS_CAL = 8'hf0;
  localparam logic [7:0] OP_SELF_GAIN_CAL = 8'hf1;
  localparam logic [7:0] OP_SYS_OFS_CAL = 8'hf2;
  localparam logic [7:0] OP_SYS_GAIN_CAL = 8'hf3;
  localparam logic [7:0] OP_SELF_FULL_CAL = 8'hf4;
  localparam logic [7:0] OP_SYNC = 8'hfc;
  localparam logic [7:0] OP_STANDBY = 8'hfd;
  localparam logic [7:0] OP_RESET = 8'hfe;

  localparam logic [4:0] RESP_SHORT_LAST = 5'h07;
  localparam logic [4:0] RESP_LONG_LAST = 5'h17;

  typedef enum logic [1:0] {
    PH_CMD = 2'b00,
    PH_ARG = 2'b01,
    PH_RESP = 2'b11
  } link_phase_t;

  typedef enum logic [1:0] {
    CONV_RUN = 2'b00,
    CONV_UPDATE = 2'b01,
    CONV_BUSY = 2'b11,
    CONV_STANDBY = 2'b10
  } conv_state_t;

  typedef enum logic [1:0] {
    EV_CMD = 2'h0,
    EV_WRITE = 2'h1,
    EV_RESP_END = 2'h2
  } link_event_kind_t;

  typedef struct packed {
    link_event_kind_t kind;
    logic [7:0] opcode;
    logic [7:0] data;
  } link_event_t;

  typedef struct packed {
    logic [3:0] positive_input_sel;
    logic [3:0] negative_input_sel;
    logic buffer_enable;
    logic [2:0] gain_amplifier;
    logic [3:0] data_rate;
  } adc_settings_t;

  // Conversion period in multiples of the fastest rate's period.
  function automatic logic [12:0] rate_ratio(input logic [3:0] code);
    case (code)
      4'h0: rate_ratio = 13'd1;
      4'h1: rate_ratio = 13'd2;
      4'h2: rate_ratio = 13'd4;
      4'h3: rate_ratio = 13'd8;
      4'h4: rate_ratio = 13'd16;
      4'h5: rate_ratio = 13'd32;
      4'h6: rate_ratio = 13'd160;
      4'h7: rate_ratio = 13'd266;
      4'h8: rate_ratio = 13'd320;
      4'h9: rate_ratio = 13'd533;
      4'ha: rate_ratio = 13'd640;
      4'hb: rate_ratio = 13'd1066;
      4'hc: rate_ratio = 13'd1600;
      4'hd: rate_ratio = 13'd3200;
      default: rate_ratio = 13'd6400;
    endcase
  endfunction

endpackage

/* File: hw/adc_serial_command_timing.sv */
`timescale 1ns/10ps
`default_nettype none
module adc_serial_command_timing
  import adc_pkg::*;
#(
  parameter int PERIOD_16K = PERIOD_16K_CYC,
  parameter int CAL_CYC = CAL_CYC_DEFAULT
) (
  // Master clock and reset
  input wire logic mclk,
  input wire logic nrst,
  // Serial port
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic din,
  output logic dout,
  output logic dout_oe,
  // Conversion control
  input wire logic sync_powerdown_n,
  input wire logic [23:0] filter_data,
  output logic result_ready_n,
  output logic filter_restart,
  // Settings
  output adc_settings_t settings
);
  link_phase_t phase;
  logic [4:0] bit_cnt;
  logic [7:0] shift;
  logic [7:0] wr_op;
  logic resp_long;
  link_event_t ev;
  logic ev_tgl;
  logic ev_fire;
  link_event_t next_ev;
  logic [7:0] next_byte;
  logic [1:0] synced;
  logic ev_seen;
  logic ev_pulse;
  logic [23:0] hold;
  logic [3:0] rel_cnt;
  logic rel_active;
  conv_state_t conv_state;
  logic [31:0] conv_cnt;
  logic [31:0] period;
  logic [23:0] result;
  logic is_resp_cmd;
  logic is_end_ev;
  logic is_cal_cmd;
  logic [7:0] reg_value;

  assign next_byte = {shift[6:0], din};

  // Link side. Chip select high aborts the frame; with chip select tied low
  // every command returns the framing to the command phase on its own.
  always_comb begin
    ev_fire = 1'b0;
    next_ev = ev;
    if (bit_cnt == 5'h07 && phase == PH_CMD && next_byte[7:4] != OP_REG_WRITE)
    begin
      ev_fire = 1'b1;
      next_ev = '{kind: EV_CMD, opcode: next_byte, data: 8'h00};
    end else if (bit_cnt == 5'h07 && phase == PH_ARG) begin
      ev_fire = 1'b1;
      next_ev = '{kind: EV_WRITE, opcode: wr_op, data: next_byte};
    end else if (phase == PH_RESP &&
                 bit_cnt == (resp_long ? RESP_LONG_LAST : RESP_SHORT_LAST))
    begin
      ev_fire = 1'b1;
      next_ev = '{kind: EV_RESP_END, opcode: ev.opcode, data: 8'h00};
    end
  end

  always_ff @(negedge sclk or negedge nrst or posedge cs_n) begin
    if (!nrst || cs_n) begin
      phase <= PH_CMD;
      bit_cnt <= 5'h00;
      shift <= 8'h00;
      wr_op <= 8'h00;
      resp_long <= 1'b0;
    end else begin
      shift <= next_byte;
      bit_cnt <= bit_cnt + 5'h01;
      case (phase)
        PH_CMD: begin
          if (bit_cnt == 5'h07) begin
            bit_cnt <= 5'h00;
            if (next_byte[7:4] == OP_REG_WRITE) begin
              phase <= PH_ARG;
              wr_op <= next_byte;
            end else if (next_byte[7:4] == OP_REG_READ) begin
              phase <= PH_RESP;
              resp_long <= 1'b0;
            end else if (next_byte == OP_READ_RESULT ||
                         next_byte == OP_READ_CONT) begin
              phase <= PH_RESP;
              resp_long <= 1'b1;
            end
          end
        end
        PH_ARG: begin
          if (bit_cnt == 5'h07) begin
            phase <= PH_CMD;
            bit_cnt <= 5'h00;
          end
        end
        PH_RESP: begin
          if (ev_fire) begin
            phase <= PH_CMD;
            bit_cnt <= 5'h00;
          end
        end
        default: phase <= PH_CMD;
      endcase
    end
  end

  // The event word is held after chip select rises so the toggle never
  // makes a false edge in the master clock domain.
  always_ff @(negedge sclk or negedge nrst) begin
    if (!nrst) begin
      ev <= '{kind: EV_CMD, opcode: OP_WAKEUP, data: 8'h00};
      ev_tgl <= 1'b0;
    end else if (ev_fire && !cs_n) begin
      ev <= next_ev;
      ev_tgl <= ~ev_tgl;
    end
  end

  // Hold is written a snapshot earlier; the host's wait before the first
  // response edge keeps it stable when this domain reads it.
  always_ff @(posedge sclk or negedge nrst or posedge cs_n) begin
    if (!nrst || cs_n) begin
      dout <= 1'b0;
    end else if (phase == PH_RESP) begin
      dout <= hold[5'(5'h17 - bit_cnt)];
    end else begin
      dout <= 1'b0;
    end
  end

  // Master clock side. Sync is carried inverted so reset reads as idle.
  bit_sync #(.WIDTH(2)) u_sync (
    .clk(mclk),
    .nrst(nrst),
    .d({ev_tgl, ~sync_powerdown_n}),
    .q(synced)
  );

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      ev_seen <= 1'b0;
    end else begin
      ev_seen <= synced[1];
    end
  end

  assign ev_pulse = synced[1] ^ ev_seen;
  assign is_resp_cmd = ev.kind == EV_CMD &&
    (ev.opcode[7:4] == OP_REG_READ || ev.opcode == OP_READ_RESULT ||
     ev.opcode == OP_READ_CONT);
  assign is_end_ev = ev.kind != EV_CMD || !is_resp_cmd;
  assign is_cal_cmd = ev.kind == EV_CMD &&
    (ev.opcode == OP_SELF_OFS_CAL || ev.opcode == OP_SELF_GAIN_CAL ||
     ev.opcode == OP_SYS_OFS_CAL || ev.opcode == OP_SYS_GAIN_CAL ||
     ev.opcode == OP_SELF_FULL_CAL || ev.opcode == OP_RESET);
  assign period = 32'(PERIOD_16K) * {19'h0, rate_ratio(settings.data_rate)};

  always_comb begin
    case (ev.opcode[1:0])
      REG_INPUT_MUX: reg_value = {settings.positive_input_sel,
                                  settings.negative_input_sel};
      REG_GAIN: reg_value = {5'h00, settings.gain_amplifier};
      REG_RATE: reg_value = {4'h0, settings.data_rate};
      default: reg_value = {7'h00, settings.buffer_enable};
    endcase
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      settings <= '{positive_input_sel: INPUT_MUX_RESET[7:4],
                    negative_input_sel: INPUT_MUX_RESET[3:0],
                    buffer_enable: 1'b0, gain_amplifier: GAIN_RESET,
                    data_rate: RATE_RESET};
    end else if (ev_pulse && ev.kind == EV_CMD && ev.opcode == OP_RESET) begin
      settings <= '{positive_input_sel: INPUT_MUX_RESET[7:4],
                    negative_input_sel: INPUT_MUX_RESET[3:0],
                    buffer_enable: 1'b0, gain_amplifier: GAIN_RESET,
                    data_rate: RATE_RESET};
    end else if (ev_pulse && ev.kind == EV_WRITE) begin
      case (ev.opcode[1:0])
        REG_INPUT_MUX: begin
          settings.positive_input_sel <= ev.data[7:4];
          settings.negative_input_sel <= ev.data[3:0];
        end
        REG_GAIN: settings.gain_amplifier <= (ev.data[2:0] > GAIN_MAX_CODE) ?
          GAIN_MAX_CODE : ev.data[2:0];
        REG_RATE: settings.data_rate <= ev.data[3:0];
        default: settings.buffer_enable <= ev.data[0];
      endcase
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      hold <= 24'h000000;
    end else if (ev_pulse && is_resp_cmd) begin
      hold <= (ev.opcode[7:4] == OP_REG_READ) ? {reg_value, 16'h0000} : result;
    end
  end

  // Chip select high clears the drive without waiting for a clock.
  always_ff @(posedge mclk or negedge nrst or posedge cs_n) begin
    if (!nrst || cs_n) begin
      dout_oe <= 1'b0;
      rel_cnt <= 4'h0;
      rel_active <= 1'b0;
    end else begin
      if (ev_pulse && is_resp_cmd) begin
        dout_oe <= 1'b1;
      end
      if (ev_pulse && is_end_ev) begin
        rel_active <= 1'b1;
        rel_cnt <= 4'h0;
      end else if (rel_active) begin
        rel_cnt <= rel_cnt + 4'h1;
        if (rel_cnt == 4'(RELEASE_CYC - 1)) begin
          dout_oe <= 1'b0;
          rel_active <= 1'b0;
        end
      end
    end
  end

  // Conversion timing. Sync low or a restarting command always wins over
  // the running count, so a pulse mid-period discards the partial result.
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      conv_state <= CONV_RUN;
      conv_cnt <= 32'h0;
      result_ready_n <= 1'b1;
      result <= 24'h000000;
      filter_restart <= 1'b0;
    end else begin
      filter_restart <= 1'b0;
      conv_cnt <= conv_cnt + 32'h1;
      if (synced[0]) begin
        conv_state <= CONV_RUN;
        conv_cnt <= 32'h0;
        result_ready_n <= 1'b1;
        filter_restart <= 1'b1;
      end else if (ev_pulse && is_cal_cmd) begin
        conv_state <= CONV_BUSY;
        conv_cnt <= 32'h0;
        result_ready_n <= 1'b1;
      end else if (ev_pulse && ev.kind == EV_CMD && ev.opcode == OP_STANDBY)
      begin
        conv_state <= CONV_STANDBY;
        result_ready_n <= 1'b1;
      end else if (ev_pulse && ev.kind == EV_CMD &&
                   (ev.opcode == OP_SYNC ||
                    (ev.opcode == OP_WAKEUP && conv_state == CONV_STANDBY)))
      begin
        conv_state <= CONV_RUN;
        conv_cnt <= 32'h0;
        filter_restart <= 1'b1;
      end else begin
        if (ev_pulse && is_resp_cmd && ev.opcode[7:4] != OP_REG_READ) begin
          result_ready_n <= 1'b1;
        end
        case (conv_state)
          CONV_RUN: begin
            if (conv_cnt >= period - 32'h1) begin
              conv_state <= CONV_UPDATE;
              conv_cnt <= 32'h0;
              result_ready_n <= 1'b1;
              result <= filter_data;
            end
          end
          CONV_UPDATE: begin
            if (conv_cnt == 32'(UPDATE_CYC - 1)) begin
              conv_state <= CONV_RUN;
              conv_cnt <= 32'h0;
              result_ready_n <= 1'b0;
            end
          end
          CONV_BUSY: begin
            if (conv_cnt == 32'(CAL_CYC - 1)) begin
              conv_state <= CONV_RUN;
              conv_cnt <= 32'h0;
              filter_restart <= 1'b1;
            end
          end
          CONV_STANDBY: conv_cnt <= 32'h0;
          default: conv_state <= CONV_RUN;
        endcase
      end
    end
  end
endmodule // adc_serial_command_timing
`default_nettype wire

/* File: hw/bit_sync.sv */
`timescale 1ns/10ps
`default_nettype none
module bit_sync #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Levels
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);
  logic [WIDTH-1:0] meta;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      meta <= '0;
      q <= '0;
    end else begin
      meta <= d;
      q <= meta;
    end
  end
endmodule // bit_sync
`default_nettype wire

/* File: tb/adc_chk.sv */
`timescale 1ns/10ps
`default_nettype none
module adc_chk
  import adc_pkg::*;
(
  // Master clock and reset
  input wire logic mclk,
  input wire logic nrst,
  // Serial port
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic din,
  input wire logic dout,
  input wire logic dout_oe,
  // Conversion and settings
  input wire logic sync_powerdown_n,
  input wire logic [23:0] filter_data,
  input wire logic result_ready_n,
  input wire logic filter_restart,
  input wire adc_settings_t settings
);
  // The serial clock is sampled on mclk, so each count may run one late.
  logic sclk_q;
  logic [4:0] since_fall;
  logic [4:0] high_run;
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      sclk_q <= 1'b0;
      since_fall <= 5'h1f;
    end else begin
      sclk_q <= sclk;
      if (sclk_q && !sclk) since_fall <= 5'h01;
      else if (since_fall != 5'h1f) since_fall <= since_fall + 5'h01;
    end
  end
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) high_run <= 5'h00;
    else if (!result_ready_n) high_run <= 5'h00;
    else if (high_run != 5'h1f) high_run <= high_run + 5'h01;
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (!nrst);
  reset_vals_a: assert property (
    $rose(nrst) |-> settings == 16'h0100 && !dout_oe && result_ready_n)
    else $error("wrong values after reset");
  cs_float_a: assert property (cs_n |-> !dout_oe)
    else $error("output enabled while deselected");
  gain_range_a: assert property (
    settings.gain_amplifier <= GAIN_MAX_CODE) else $error("bad gain code");
  oe_release_a: assert property (
    $fell(dout_oe) && !cs_n |-> since_fall inside {[6:10]})
    else $error("output released at the wrong time");
  update_gap_a: assert property (
    $fell(result_ready_n) |-> high_run >= 5'h10)
    else $error("ready without a full update gap");
  sync_hold_a: assert property (
    !sync_powerdown_n [*5] |-> result_ready_n && filter_restart)
    else $error("sync low did not hold the conversion");
  dout_launch_a: assert property (
    $changed(dout) && dout_oe && !cs_n |-> sclk)
    else $error("output bit moved away from a rising edge");
  set_source_a: assert property (
    $changed(settings) |-> !cs_n && since_fall inside {[1:6]})
    else $error("settings changed without a command");
endmodule // adc_chk
bind adc_serial_command_timing adc_chk i_adc_chk (.mclk, .nrst, .sclk,
  .cs_n, .din, .dout, .dout_oe, .sync_powerdown_n, .filter_data,
  .result_ready_n, .filter_restart, .settings);
`default_nettype wire

/* File: tb/host_model.sv */
`timescale 1ns/10ps
`default_nettype none
module host_model (
  // Master clock
  input wire logic mclk,
  // Serial port
  input wire logic dout,
  output logic sclk,
  output logic cs_n,
  output logic din
);
  logic hold_low;
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    din = 1'b1;
    hold_low = 1'b0;
  end
  // The serial clock period is 32 ns, four master clocks, the shortest the
  // port takes; it stands low between frames.
  task automatic shift8(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      sclk = 1'b1;
      din = tx[i];
      #16;
      rx = {rx[6:0], dout};
      sclk = 1'b0;
      #16;
    end
  endtask
  // Kind 0 sends one byte, 1 adds a data byte, 8 or 24 read that many bits,
  // 16 cuts a result read short by raising chip select.
  task automatic cmd(input logic [7:0] op, input logic [7:0] arg,
    input int kind, output logic [23:0] rx);
    logic [7:0] b;
    rx = 24'h000000;
    @(posedge mclk);
    cs_n <= 1'b0;
    @(posedge mclk);
    #3;
    shift8(op, b);
    if (kind == 1) shift8(arg, b);
    if (kind > 1) begin
      repeat (50) @(posedge mclk);
      #3;
      repeat (kind / 8) begin
        shift8(8'h00, b);
        rx = {rx[15:0], b};
      end
    end
    if (kind != 16) repeat (8) @(posedge mclk);
    if (!hold_low) cs_n <= 1'b1;
    din = ~din;
    repeat (24) @(posedge mclk);
  endtask
endmodule // host_model
`default_nettype wire

/* File: tb/testbench.sv */
`timescale 1ns/10ps
`default_nettype none
module testbench;
  import adc_pkg::*;
  logic mclk = 1'b0;
  logic nrst = 1'b1;
  logic sync_powerdown_n = 1'b1;
  logic [23:0] filter_data = 24'h000000;
  wire logic sclk, cs_n, din, dout, dout_oe, result_ready_n, filter_restart;
  wire adc_settings_t settings;
  logic [23:0] rx;
  int fail_count = 0;
  int n_tests = 0;
  always #4 mclk = ~mclk;
  adc_serial_command_timing #(.PERIOD_16K(40), .CAL_CYC(20))
    i_adc_serial_command_timing (.mclk(mclk), .nrst(nrst), .sclk(sclk),
    .cs_n(cs_n), .din(din), .dout(dout), .dout_oe(dout_oe),
    .sync_powerdown_n(sync_powerdown_n), .filter_data(filter_data),
    .result_ready_n(result_ready_n), .filter_restart(filter_restart),
    .settings(settings));
  host_model i_host_model (.mclk(mclk), .dout(dout), .sclk(sclk),
    .cs_n(cs_n), .din(din));
  task automatic check(input logic [23:0] seen, input logic [23:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic print_verdict;
    if (fail_count == 0 && n_tests > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic wait_ready(input logic lvl);
    int n;
    n = 0;
    while (result_ready_n !== lvl && n < 4000) begin
      @(posedge mclk);
      n++;
    end
    if (n == 4000) begin
      check(24'h000001, 24'h000000);
      print_verdict();
    end
  endtask
  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    i_host_model.cmd({OP_REG_WRITE, 2'h0, a}, d, 1, rx);
  endtask
  task automatic t_reset;
    @(negedge mclk);
    check({6'h00, dout_oe, result_ready_n, settings}, 24'h010100);
  endtask
  task automatic t_regs;
    wr(REG_INPUT_MUX, 8'h72);
    check({16'h0000, settings[15:8]}, 24'h000072);
    i_host_model.cmd({OP_REG_READ, 2'h0, REG_INPUT_MUX}, 8'h00, 8, rx);
    check(rx, 24'h000072);
    check({23'h0, dout_oe}, 24'h000000);
    for (int g = 0; g < 8; g++) begin
      wr(REG_GAIN, 8'(g));
      check({21'h0, settings.gain_amplifier}, 24'((g > 6) ? 6 : g));
    end
    for (int r = 15; r >= 0; r -= 5) begin
      wr(REG_RATE, 8'(r));
      check({20'h0, settings.data_rate}, 24'(r));
    end
    wr(REG_BUFFER, 8'h01);
    check({23'h0, settings.buffer_enable}, 24'h000001);
  endtask
  task automatic t_cs_low;
    i_host_model.hold_low = 1'b1;
    wr(REG_GAIN, 8'h05);
    wr(REG_INPUT_MUX, 8'h34);
    check({12'h000, settings[15:4]}, 24'h00034d);
    i_host_model.hold_low = 1'b0;
  endtask
  // The reset command goes first so that the input, gain and buffer settings left by
  // the register scenarios are back at reset values for the final check.
  task automatic t_cal;
    logic [7:0] ops [9] = '{OP_RESET, OP_SELF_OFS_CAL, OP_SELF_GAIN_CAL,
      OP_SYS_OFS_CAL, OP_SYS_GAIN_CAL, OP_SELF_FULL_CAL, OP_SYNC,
      OP_STANDBY, OP_WAKEUP};
    for (int k = 0; k < 9; k++) begin
      i_host_model.cmd(ops[k], 8'h00, 0, rx);
      if (ops[k] != OP_STANDBY) begin
        wait_ready(1'b1);
        wait_ready(1'b0);
      end
    end
    check({8'h00, settings}, 24'h000100);
  endtask
  task automatic t_read;
    filter_data <= 24'ha5c3e1;
    repeat (2) begin
      wait_ready(1'b1);
      wait_ready(1'b0);
    end
    i_host_model.cmd(OP_READ_RESULT, 8'h00, 24, rx);
    check(rx, 24'ha5c3e1);
    check({23'h0, dout_oe}, 24'h000000);
    i_host_model.cmd(OP_READ_CONT, 8'h00, 24, rx);
    check(rx, 24'ha5c3e1);
    i_host_model.cmd(OP_READ_RESULT, 8'h00, 16, rx);
    check(rx, 24'h00a5c3);
    check({23'h0, dout_oe}, 24'h000000);
  endtask
  task automatic t_sync;
    sync_powerdown_n <= 1'b0;
    repeat (6) @(posedge mclk);
    @(negedge mclk);
    check({22'h0, result_ready_n, filter_restart}, 24'h000003);
    @(posedge mclk);
    sync_powerdown_n <= 1'b1;
    wait_ready(1'b0);
  endtask
  initial begin
    // Reset falls at time zero through a nonblocking write so that every process sees the edge.
    nrst <= 1'b0;
    repeat (4) @(posedge mclk);
    nrst <= 1'b1;
    t_reset();
    t_regs();
    t_cs_low();
    t_cal();
    t_read();
    t_sync();
    @(posedge mclk);
    nrst <= 1'b0;
    repeat (4) @(posedge mclk);
    nrst <= 1'b1;
    t_reset();
    print_verdict();
  end
endmodule // testbench
`default_nettype wire
